// ---- sadc_sequencer.sv ----
`default_nettype none

module sadc_sequencer (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  // Register port
  input wire logic [sadc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sadc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [sadc_pkg::DATA_W-1:0] RDATA,
  // Converter input clock from the oscillator, asynchronous
  input wire logic CRYSTAL_CLOCK,
  // Analog front end
  input wire logic COMP_HI,
  output logic [7:0] DAC_CODE,
  output logic [7:0] ANALOG_SEL,
  output logic REF_HI_SEL,
  output logic REF_LO_SEL,
  output logic CONV_ON,
  // Shared port pins and the port logic behind them
  input wire logic [7:0] PORT_DATA,
  input wire logic [7:0] PORT_DIR,
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE_N,
  output logic [7:0] PORT_READ,
  // Low-power modes and interrupt
  input wire logic STOP_MODE,
  output logic IRQ
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] pin_claim(input logic [4:0] chan);
    pin_claim = (chan[4:3] == 2'b00) ? (8'h01 << chan[2:0]) : 8'h00;
  endfunction

  function automatic logic [3:0] div_limit(input logic [2:0] code);
    unique case (code)
      3'h0: div_limit = 4'h0;
      3'h1: div_limit = 4'h1;
      3'h2: div_limit = 4'h3;
      3'h3: div_limit = 4'h7;
      default: div_limit = 4'hf;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sadc_pkg::sadc_ctrl_type ctrl_r;
  sadc_pkg::sadc_clk_type clk_r;
  sadc_pkg::sadc_state_type state_r, state_nxt;
  logic [7:0] result_r;
  logic [7:0] trial_r, trial_nxt;
  logic [3:0] cyc_r, cyc_nxt;
  logic [3:0] div_cnt_r;
  logic done_r, done_nxt;
  logic irq_r, irq_nxt;
  logic run_pend_r, run_pend_nxt;
  logic [7:0] rdata_r;
  logic xtal_s1_r, xtal_s2_r, xtal_d_r;
  logic comp_s1_r, comp_s2_r;
  logic [7:0] pin_s1_r, pin_s2_r;
  logic [7:0] pin_out_r, oe_n_r, port_read_r, sel_r;
  logic ref_hi_r, ref_lo_r, conv_on_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire ctrl_wr = WR && (ADDR == sadc_pkg::OFS_CTRL);
  wire clk_wr = WR && (ADDR == sadc_pkg::OFS_CLOCK);
  wire result_rd = RD && (ADDR == sadc_pkg::OFS_RESULT);
  wire flag_clear = ctrl_wr || result_rd;
  wire [4:0] chan = ctrl_r.channel_select;
  wire [4:0] new_chan = WDATA[4:0];
  wire powered = (chan != sadc_pkg::CHAN_OFF);
  wire new_powered = (new_chan != sadc_pkg::CHAN_OFF);
  // Bit read as done: a plain flag, or low while an interrupt is pending
  wire done_view = ctrl_r.done_irq_enable ? !irq_r : done_r;
  wire [7:0] ctrl_view = {done_view, ctrl_r.done_irq_enable,
                          ctrl_r.continuous_mode_bit, chan};
  wire [7:0] rd_mux = (ADDR == sadc_pkg::OFS_CTRL) ? ctrl_view :
                      (ADDR == sadc_pkg::OFS_RESULT) ? result_r :
                      (ADDR == sadc_pkg::OFS_CLOCK) ? clk_r : 8'h00;

  // ---------------------------------------------------------------
  // Converter clock: source select and divider
  // ---------------------------------------------------------------
  // The crystal clock is sampled, not used as a clock, so the whole block
  // stays on MCLK; the crystal must run well below MCLK for this to hold.
  wire xtal_rise = xtal_s2_r && !xtal_d_r;
  wire src_tick = clk_r.converter_clock_source ? 1'b1 : xtal_rise;
  wire [3:0] limit = div_limit(clk_r.converter_clock_divider);
  wire conv_tick = src_tick && (div_cnt_r == limit);

  // ---------------------------------------------------------------
  // Successive approximation step
  // ---------------------------------------------------------------
  wire [7:0] bit_mask = 8'h80 >> cyc_r[3:1];
  wire [7:0] kept = comp_s2_r ? trial_r : (trial_r & ~bit_mask);
  wire decide = conv_tick && (state_r == sadc_pkg::ST_CONV) && cyc_r[0];
  wire conv_done = decide && (cyc_r == sadc_pkg::CONV_LAST_CYC);
  wire single_end = conv_done && !ctrl_r.continuous_mode_bit;
  wire start_req = ctrl_wr && new_powered && !STOP_MODE;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    trial_nxt = trial_r;
    cyc_nxt = cyc_r;
    unique case (state_r)
      sadc_pkg::ST_IDLE:
      begin
        // Picks up a conversion held over a stop period
        if (run_pend_r && powered && !STOP_MODE)
          state_nxt = sadc_pkg::ST_SYNC;
      end
      sadc_pkg::ST_SYNC:
      begin
        // Waiting for the next converter edge makes the 16-to-17 spread
        if (conv_tick)
        begin
          state_nxt = sadc_pkg::ST_CONV;
          cyc_nxt = 4'h0;
          trial_nxt = sadc_pkg::TRIAL_FIRST;
        end
      end
      sadc_pkg::ST_CONV:
      begin
        if (conv_tick)
        begin
          cyc_nxt = cyc_r + 4'h1;
          if (cyc_r[0])
            trial_nxt = kept | (bit_mask >> 1);
          if (conv_done)
            state_nxt = (ctrl_r.continuous_mode_bit && powered) ?
                        sadc_pkg::ST_SYNC : sadc_pkg::ST_IDLE;
        end
      end
    endcase
    if (start_req)
      state_nxt = sadc_pkg::ST_SYNC;
    else if (ctrl_wr && !new_powered)
      state_nxt = sadc_pkg::ST_IDLE;
    if (STOP_MODE)
      state_nxt = sadc_pkg::ST_IDLE;
  end

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  always_comb
  begin
    run_pend_nxt = run_pend_r;
    if (single_end)
      run_pend_nxt = 1'b0;
    if (ctrl_wr)
      run_pend_nxt = new_powered;
    // A completion in the clearing cycle still leaves the flag set
    done_nxt = done_r;
    if (flag_clear)
      done_nxt = 1'b0;
    if (conv_done && !ctrl_r.done_irq_enable)
      done_nxt = 1'b1;
    irq_nxt = irq_r;
    if (flag_clear || !ctrl_r.done_irq_enable)
      irq_nxt = 1'b0;
    if (conv_done && ctrl_r.done_irq_enable)
      irq_nxt = 1'b1;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_r <= sadc_pkg::RST_CTRL;
      clk_r <= sadc_pkg::RST_CLOCK;
      result_r <= sadc_pkg::RST_RESULT;
      rdata_r <= 8'h00;
    end
    else if (CE)
    begin
      if (ctrl_wr)
        ctrl_r <= {1'b0, WDATA[6:0]};
      if (clk_wr)
        clk_r <= {WDATA[7:4], 4'h0};
      if (conv_done)
        result_r <= kept;
      rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_r <= sadc_pkg::ST_IDLE;
      trial_r <= 8'h00;
      cyc_r <= 4'h0;
      done_r <= 1'b0;
      irq_r <= 1'b0;
      run_pend_r <= 1'b0;
    end
    else if (CE)
    begin
      state_r <= state_nxt;
      trial_r <= trial_nxt;
      cyc_r <= cyc_nxt;
      done_r <= done_nxt;
      irq_r <= irq_nxt;
      run_pend_r <= run_pend_nxt;
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      div_cnt_r <= 4'h0;
    else if (CE && src_tick)
      div_cnt_r <= (div_cnt_r >= limit) ? 4'h0 : div_cnt_r + 4'h1;
  end

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      xtal_s1_r <= 1'b0;
      xtal_s2_r <= 1'b0;
      xtal_d_r <= 1'b0;
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end
    else if (CE)
    begin
      xtal_s1_r <= CRYSTAL_CLOCK;
      xtal_s2_r <= xtal_s1_r;
      xtal_d_r <= xtal_s2_r;
      comp_s1_r <= COMP_HI;
      comp_s2_r <= comp_s1_r;
      pin_s1_r <= PIN_IN;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Pin sharing and analog select
  // ---------------------------------------------------------------
  // Claim follows the select field alone, so a pin stays an analog input
  // between conversions and does not toggle as a digital output.
  wire [7:0] claim = pin_claim(chan);

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pin_out_r <= 8'h00;
      oe_n_r <= 8'hff;
      port_read_r <= 8'h00;
      sel_r <= 8'h00;
      ref_hi_r <= 1'b0;
      ref_lo_r <= 1'b0;
      conv_on_r <= 1'b0;
    end
    else if (CE)
    begin
      pin_out_r <= PORT_DATA & ~claim;
      oe_n_r <= ~(PORT_DIR & ~claim);
      port_read_r <= pin_s2_r & ~claim;
      sel_r <= claim;
      ref_hi_r <= (chan == sadc_pkg::CHAN_REF_HI);
      ref_lo_r <= (chan == sadc_pkg::CHAN_REF_LO);
      conv_on_r <= powered && !STOP_MODE;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign RDATA = rdata_r;
  assign DAC_CODE = trial_r;
  assign ANALOG_SEL = sel_r;
  assign REF_HI_SEL = ref_hi_r;
  assign REF_LO_SEL = ref_lo_r;
  assign CONV_ON = conv_on_r;
  assign PIN_OUT = pin_out_r;
  assign PIN_OE_N = oe_n_r;
  assign PORT_READ = port_read_r;
  assign IRQ = irq_r;

endmodule // sadc_sequencer

`default_nettype wire

// ---- sadc_pkg.sv ----
// How it works
// - One of eight channels is muxed into one converter with 8-bit results.
// - At conversion end the result is stored and flag or interrupt raised in the same cycle.
// - Selected pin is forced to converter input; port writes cannot drive it.
// - Port reads of the claimed pin return 0.
// - Unselected pins stay ordinary port inputs and outputs.
// - Input at high reference gives all ones, low reference zero, linear between.
// - A control write starts a conversion lasting 16 to 17 converter clocks.
// - Continuous mode overwrites the result after every conversion.
// - Continuous conversions repeat until the continuous bit is cleared.
// - Continuous done flag sets after first conversion, held until write or read.
// - Single mode does one conversion per control write, then idles.
// - With interrupt enabled each conversion requests an interrupt; flag reads low while it is pending.
// - Results are monotonic with no missing codes.
// - Converter keeps running in wait; its interrupt can wake the processor.
// - Stop aborts and idles the converter; conversions resume after stop ends.
// - Five-bit select: 0-7 pins, references, all ones off, rest reserved.
// - Without interrupt, done flag is read-only, cleared by write/read and reset.
// - Pending interrupt is withdrawn by result read or control write.
// - Three-bit divider 1,2,4,8,16; source bit picks bus or crystal clock.
`default_nettype none

package sadc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_CLOCK = 2'h2;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic conversion_done_flag;
    logic done_irq_enable;
    logic continuous_mode_bit;
    logic [4:0] channel_select;
  } sadc_ctrl_type;

  typedef struct packed {
    logic [2:0] converter_clock_divider;
    logic converter_clock_source;
    logic [3:0] unused;
  } sadc_clk_type;

  localparam logic [4:0] CHAN_REF_HI = 5'h1d;
  localparam logic [4:0] CHAN_REF_LO = 5'h1e;
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  localparam int NUM_CHAN = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h1f;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_CLOCK = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [3:0] CONV_LAST_CYC = 4'hf;
  localparam logic [7:0] TRIAL_FIRST = 8'h80;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_CONV = 2'b11
  } sadc_state_type;

endpackage

`default_nettype wire

// ---- sadc_assertions.sv ----
`default_nettype none

// ------------------------------------------------------------
// Port checker for the converter sequencer
// ------------------------------------------------------------
module sadc_assertions (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [sadc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sadc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [sadc_pkg::DATA_W-1:0] RDATA,
  // Analog side and pins
  input wire logic [7:0] DAC_CODE,
  input wire logic [7:0] ANALOG_SEL,
  input wire logic REF_HI_SEL,
  input wire logic REF_LO_SEL,
  input wire logic CONV_ON,
  input wire logic [7:0] PORT_DATA,
  input wire logic [7:0] PORT_DIR,
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE_N,
  input wire logic [7:0] PORT_READ,
  input wire logic STOP_MODE,
  input wire logic IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  logic slow_r;
  logic ctrl_wr;
  logic start;
  assign ctrl_wr = WR && ADDR == sadc_pkg::OFS_CTRL;
  assign start = ctrl_wr && WDATA[4:0] != sadc_pkg::CHAN_OFF && !STOP_MODE && slow_r;
  // Timing figures below only hold for the bus clock divided by 16
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
      slow_r <= 1'b0;
    else if (WR && ADDR == sadc_pkg::OFS_CLOCK)
      slow_r <= WDATA[7] && WDATA[4];

  property p_claim_oe;
    (ANALOG_SEL & ~PIN_OE_N) == 8'h00;
  endproperty
  a_claim_oe: assert property (p_claim_oe) else $error("claimed pin driven");
  property p_claim_read;
    (ANALOG_SEL & PORT_READ) == 8'h00;
  endproperty
  a_claim_read: assert property (p_claim_read) else $error("claimed pin reads 1");
  property p_free;
    ANALOG_SEL == 8'h00 && $past(ANALOG_SEL) == 8'h00 && !STOP_MODE && !$past(STOP_MODE)
      |-> PIN_OE_N == ~$past(PORT_DIR) && PIN_OUT == $past(PORT_DATA);
  endproperty
  a_free: assert property (p_free) else $error("free pin not under port");
  property p_first_trial;
    start |-> ##[2:20] DAC_CODE == sadc_pkg::TRIAL_FIRST;
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("no first trial");
  property p_irq_time;
    start && WDATA[6] |=> !IRQ [*8] ##[240:292] IRQ;
  endproperty
  a_irq_time: assert property (p_irq_time) else $error("irq timing");
  property p_irq_drop;
    ctrl_wr && !WDATA[6] |-> ##2 !IRQ;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq not withdrawn");
  property p_clk_rd;
    RD && ADDR == sadc_pkg::OFS_CLOCK |=> RDATA[3:0] == 4'h0;
  endproperty
  a_clk_rd: assert property (p_clk_rd) else $error("clock low nibble");
  property p_stop;
    STOP_MODE |=> !CONV_ON;
  endproperty
  a_stop: assert property (p_stop) else $error("active in stop");
  property p_off;
    ctrl_wr && WDATA[4:0] == sadc_pkg::CHAN_OFF ##1 !ctrl_wr |=> !CONV_ON;
  endproperty
  a_off: assert property (p_off) else $error("not powered off");
  property p_onehot;
    $onehot0({ANALOG_SEL, REF_HI_SEL, REF_LO_SEL});
  endproperty
  a_onehot: assert property (p_onehot) else $error("mux not one-hot");
endmodule // sadc_assertions

bind sadc_sequencer sadc_assertions u_chk (
  .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .DAC_CODE(DAC_CODE), .ANALOG_SEL(ANALOG_SEL), .REF_HI_SEL(REF_HI_SEL),
  .REF_LO_SEL(REF_LO_SEL), .CONV_ON(CONV_ON), .PORT_DATA(PORT_DATA), .PORT_DIR(PORT_DIR),
  .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PORT_READ(PORT_READ), .STOP_MODE(STOP_MODE),
  .IRQ(IRQ)
);

`default_nettype wire

// ---- sadc_analog_model.sv ----
`default_nettype none

// ------------------------------------------------------------
// Analog sources and shared pins
// ------------------------------------------------------------
module sadc_analog_model (
  // Clock
  input wire logic MCLK,
  // Converter side
  input wire logic [7:0] DAC_CODE,
  input wire logic [7:0] ANALOG_SEL,
  input wire logic REF_HI_SEL,
  input wire logic REF_LO_SEL,
  input wire logic CONV_ON,
  output logic COMP_HI,
  // Pin side
  input wire logic [63:0] LEVELS,
  input wire logic [7:0] PIN_EXT,
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE_N,
  output logic [7:0] PIN_IN
);
  logic [7:0] vin;
  logic flip_r = 1'b0;
  // Unpowered comparator wanders rather than holding its last answer
  always_ff @(posedge MCLK)
    flip_r <= !flip_r;
  always_comb
  begin
    vin = 8'h00;
    for (int i = 0; i < 8; i++)
      if (ANALOG_SEL[i])
        vin = LEVELS[i*8 +: 8];
    if (REF_HI_SEL)
      vin = 8'hff;
    if (REF_LO_SEL)
      vin = 8'h00;
  end
  assign COMP_HI = CONV_ON ? (vin >= DAC_CODE) : flip_r;
  assign PIN_IN = (PIN_OUT & ~PIN_OE_N) | (PIN_EXT & PIN_OE_N);
endmodule // sadc_analog_model

`default_nettype wire

// ---- sadc_sequencer_tb.sv ----
`default_nettype none

// ------------------------------------------------------------
// Converter sequencer bench
// ------------------------------------------------------------
module sadc_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] CTL = sadc_pkg::OFS_CTRL;
  localparam logic [1:0] RES = sadc_pkg::OFS_RESULT;
  localparam logic [1:0] CLK = sadc_pkg::OFS_CLOCK;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, xtal = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic stop = 1'b0, comp, ref_hi, ref_lo, conv_on, irq;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, port_data = 8'h00, port_dir = 8'h00, pin_ext = 8'hff;
  logic [7:0] rdata, dac, asel, pin_in, pin_out, pin_oe_n, port_read;
  logic [63:0] lv = 64'h96013c407f81c3f0;
  int bad_count = 0;
  int compares = 0;

  sadc_sequencer u_dut (.MCLK(mclk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .CRYSTAL_CLOCK(xtal), .COMP_HI(comp),
    .DAC_CODE(dac), .ANALOG_SEL(asel), .REF_HI_SEL(ref_hi), .REF_LO_SEL(ref_lo),
    .CONV_ON(conv_on), .PORT_DATA(port_data), .PORT_DIR(port_dir), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PORT_READ(port_read), .STOP_MODE(stop),
    .IRQ(irq));
  sadc_analog_model u_ana (.MCLK(mclk), .DAC_CODE(dac), .ANALOG_SEL(asel),
    .REF_HI_SEL(ref_hi), .REF_LO_SEL(ref_lo), .CONV_ON(conv_on), .COMP_HI(comp),
    .LEVELS(lv), .PIN_EXT(pin_ext), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .PIN_IN(pin_in));

  initial forever #25 mclk = ~mclk;

  // Crystal runs well below the bus clock so its edges survive the sampling
  initial forever #100 xtal = ~xtal;

  task automatic give_verdict();
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_done();
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 300 && d[7] !== 1'b1; i++)
      rd(CTL, d);
    chk("done flag", 8'h80, d & 8'h80);
  endtask

  task automatic conv(input logic [7:0] e);
    logic [7:0] d;
    wait_done();
    rd(RES, d);
    chk("result", e, d);
    rd(CTL, d);
    chk("flag after read", 8'h00, d & 8'h80);
  endtask

  task automatic t_xtal();
    logic [7:0] d;
    rd(CTL, d);
    chk("ctrl reset", sadc_pkg::RST_CTRL, d);
    rd(CLK, d);
    chk("clock reset", sadc_pkg::RST_CLOCK, d);
    wr(CTL, 8'h00);
    conv(lv[7:0]);
  endtask

  task automatic t_single();
    logic [7:0] d;
    wr(CLK, 8'h90);
    rd(CLK, d);
    chk("clock reg", 8'h90, d);
    for (int c = 0; c < 8; c++)
    begin
      wr(CTL, 8'(c));
      conv(lv[c*8 +: 8]);
    end
    wr(CTL, {3'b000, sadc_pkg::CHAN_REF_HI});
    conv(8'hff);
    wr(CTL, {3'b000, sadc_pkg::CHAN_REF_LO});
    conv(8'h00);
  endtask

  task automatic t_irq();
    logic [7:0] d;
    wr(CLK, 8'hf0);
    rd(CLK, d);
    chk("clock reg", 8'hf0, d);
    wr(CTL, 8'h43);
    for (int i = 0; i < 400 && irq !== 1'b1; i++)
      @(negedge mclk);
    chk("irq raised", 8'h01, {7'h00, irq});
    rd(CTL, d);
    chk("irq flag", 8'h00, d & 8'h80);
    rd(RES, d);
    chk("irq result", lv[24 +: 8], d);
    chk("irq withdrawn", 8'h00, {7'h00, irq});
  endtask

  task automatic t_cont();
    logic [7:0] d;
    wr(CTL, 8'h27);
    wait_done();
    lv[56 +: 8] = 8'h5a;
    repeat (700) @(posedge mclk);
    rd(CTL, d);
    chk("cont flag", 8'h80, d & 8'h80);
    rd(RES, d);
    chk("cont result", 8'h5a, d);
    wr(CTL, 8'h07);
    wait_done();
    rd(RES, d);
    repeat (700) @(posedge mclk);
    rd(CTL, d);
    chk("no repeat", 8'h00, d & 8'h80);
    wr(CTL, 8'h1f);
    repeat (3) @(posedge mclk);
    #1;
    chk("powered down", 8'h00, {7'h00, conv_on});
  endtask

  task automatic t_stop_restart();
    logic [7:0] d;
    wr(CTL, 8'h04);
    repeat (50) @(posedge mclk);
    stop <= 1'b1;
    repeat (400) @(posedge mclk);
    rd(CTL, d);
    chk("stop flag", 8'h00, d & 8'h80);
    stop <= 1'b0;
    conv(lv[32 +: 8]);
    wr(CTL, 8'h05);
    repeat (100) @(posedge mclk);
    wr(CTL, 8'h06);
    conv(lv[48 +: 8]);
  endtask

  task automatic t_port();
    @(posedge mclk);
    port_data <= 8'h55;
    port_dir <= 8'hff;
    wr(CTL, 8'h02);
    repeat (8) @(posedge mclk);
    #1;
    chk("pin enable", 8'h04, pin_oe_n);
    chk("pin drive", 8'h51, pin_out);
    chk("port read", 8'h51, port_read);
    port_dir <= 8'h00;
    repeat (8) @(posedge mclk);
    #1;
    chk("input read", 8'hfb, port_read);
    // Clock enable low must freeze the registered pin view
    @(posedge mclk);
    ce <= 1'b0;
    port_dir <= 8'hff;
    repeat (6) @(posedge mclk);
    #1;
    chk("frozen read", 8'hfb, port_read);
    @(posedge mclk);
    ce <= 1'b1;
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_xtal();
    t_single();
    t_irq();
    wr(CLK, 8'h90);
    t_cont();
    t_stop_restart();
    t_port();
    give_verdict();
  end

  // Whole run needs about 6300 cycles
  initial
  begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end
endmodule // sadc_sequencer_tb

`default_nettype wire
